/* File: hdl/cs_pro_pkg.sv */
// Constants, codes and types for the professional channel status decoder
// How it works
// - Hold the 192-bit status block as 24 read-only bytes, LSBs lowest.
// - Byte 0 bits 7:6 give base rate: none, 48k, 44.1k or 32k.
// - Byte 0 bits 4:2 give emphasis: none-indicated, none, CD-type, J-17.
// - Byte 1 bits 7:4 give user bit management scheme.
// - Byte 1 bits 3:0 give channel mode: two channel, mono, primary/secondary.
// - Further modes: stereo, user, double-rate single channel variants, multichannel.
// - Byte 2 bits 7:6 give alignment level: none, -20 dBFS, -18.06 dBFS.
// - Unless byte 2 bits 2:0 give the main audio aux code, byte 2 bits 5:3 give source word length.
// - Byte 2 bits 2:0 give auxiliary sample word use.
// - Byte 3 bit 7 low: channel is one plus bit-reversed bits 6:0.
// - Byte 3 bit 7 high: bits 6:4 multichannel mode, reversed bits 3:0 channel.
// - Byte 4 scaling flag high means rate multiplied by 1/1.001.
// - Byte 4 extended rate field decodes 22.05k through 192k and user defined.
package cs_pro_pkg;
	localparam int         CS_BITS   = 192;
	localparam int         CS_BYTES  = 24;
	localparam int         ADDR_W    = 5;
	localparam int         CNT_W     = 8;
	localparam logic [7:0] LAST_BIT  = 8'hBF;
	localparam logic [7:0] CNT_FIRST = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// Byte offsets of the decoded bytes
	localparam logic [4:0] OFS_RATE_EMPHASIS = 5'h00;
	localparam logic [4:0] OFS_USER_CHMODE   = 5'h01;
	localparam logic [4:0] OFS_LEVEL_WORDLEN = 5'h02;
	localparam logic [4:0] OFS_CHANNEL_ID    = 5'h03;
	localparam logic [4:0] OFS_EXT_RATE      = 5'h04;
	localparam logic [4:0] OFS_LAST          = 5'h17;

	// Field layouts of bytes 0 to 4, first member is bit 7
	typedef struct packed {
		logic [1:0] rate;
		logic       unlocked;
		logic [2:0] emph;
		logic       non_audio;
		logic       professional;
	} byte0_t;
	typedef struct packed {
		logic [3:0] user_mgmt;
		logic [3:0] chan_mode;
	} byte1_t;
	typedef struct packed {
		logic [1:0] align;
		logic [2:0] word_len;
		logic [2:0] aux;
	} byte2_t;
	typedef struct packed {
		logic       multi;
		logic [6:0] chan;
	} byte3_t;
	typedef struct packed {
		logic       fs_scale;
		logic [3:0] ext_rate;
		logic [2:0] other;
	} byte4_t;

	typedef enum logic [1:0] {FS_NONE, FS_48K, FS_44K1, FS_32K} base_rate_t;
	typedef enum logic [2:0] {EMPH_NOT_IND, EMPH_NONE, EMPH_CD, EMPH_J17, EMPH_OTHER} emph_t;
	typedef enum logic [2:0] {UB_NONE, UB_CHSTAT, UB_AES18, UB_USER, UB_CONSUMER, UB_OTHER} user_mgmt_t;
	typedef enum logic [3:0] {CM_NOT_IND, CM_TWO, CM_MONO, CM_PRI_SEC, CM_STEREO, CM_USER,
		CM_SCDR, CM_SCDR_LEFT, CM_SCDR_RIGHT, CM_MULTI, CM_OTHER} chan_mode_t;
	typedef enum logic [1:0] {AL_NONE, AL_M20, AL_M18, AL_OTHER} align_t;
	typedef enum logic [1:0] {AUX_UNDEF, AUX_MAIN, AUX_COORD, AUX_RSVD} aux_t;
	typedef enum logic [2:0] {XR_NONE, XR_24K, XR_22K05, XR_88K2, XR_176K4, XR_192K, XR_USER} ext_rate_t;

	// Raw codes
	localparam logic [1:0] FS_C48 = 2'h2, FS_C44 = 2'h1, FS_C32 = 2'h3;
	localparam logic [2:0] EM_C_NONE = 3'h1, EM_C_CD = 3'h3, EM_C_J17 = 3'h7, EM_C_NI = 3'h0;
	localparam logic [3:0] UB_C_NONE = 4'h0, UB_C_CS = 4'h8, UB_C_AES = 4'h4, UB_C_USR = 4'hC, UB_C_CON = 4'h2;
	localparam logic [3:0] CM_C_NI = 4'h0, CM_C_TWO = 4'h8, CM_C_MONO = 4'h4, CM_C_PS = 4'hC;
	localparam logic [3:0] CM_C_ST = 4'h2, CM_C_U1 = 4'hA, CM_C_U2 = 4'h6, CM_C_SD = 4'hE;
	localparam logic [3:0] CM_C_SDL = 4'h1, CM_C_SDR = 4'h9, CM_C_MC = 4'hF;
	localparam logic [1:0] AL_C_NONE = 2'h0, AL_C_20 = 2'h2, AL_C_18 = 2'h1;
	localparam logic [2:0] WL_C_23 = 3'h4, WL_C_22 = 3'h2, WL_C_21 = 3'h6, WL_C_20 = 3'h1, WL_C_24 = 3'h5;
	localparam logic [4:0] WL_23 = 5'h17, WL_22 = 5'h16, WL_21 = 5'h15, WL_20 = 5'h14, WL_24 = 5'h18;
	localparam logic [4:0] WL_NI = 5'h00;
	localparam logic [2:0] AX_C_UNDEF = 3'h0, AX_C_MAIN = 3'h4, AX_C_COORD = 3'h2;
	localparam logic [3:0] XR_C_24 = 4'h1, XR_C_22 = 4'h9, XR_C_88 = 4'h5, XR_C_176 = 4'hB;
	localparam logic [3:0] XR_C_192 = 4'h3, XR_C_USER = 4'hF;
	localparam logic [7:0] CHAN_ONE = 8'h01;

	// Decoded view of bytes 0 to 4
	typedef struct packed {
		base_rate_t base_rate;
		logic       locked;
		emph_t      emph;
		logic       non_audio;
		logic       professional;
		user_mgmt_t user_mgmt;
		chan_mode_t chan_mode;
		align_t     align;
		logic [4:0] word_len;
		aux_t       aux;
		logic       multi;
		logic [2:0] multi_mode;
		logic [7:0] chan_num;
		logic       fs_scaled;
		ext_rate_t  ext_rate;
	} cs_decoded_t;
endpackage

/* File: hdl/pro_channel_status_decoder.sv */
// Capture, holding window and decoder for the professional channel status block
`timescale 1ns/1ns
module pro_channel_status_decoder (
	input  wire logic                            mclk,
	input  wire logic                            resetn,
	input  wire logic                            frame_valid,
	input  wire logic                            block_start,
	input  wire logic                            cs_bit,
	input  wire logic                            rd_en,
	input  wire logic [cs_pro_pkg::ADDR_W-1:0]   rd_addr,
	output logic      [7:0]                      rd_data,
	output logic                                 block_ready,
	output cs_pro_pkg::cs_decoded_t              decoded
);
	typedef enum logic {SYNC_WAIT, CAPTURE} cap_state_t;

	cap_state_t                        state_r, state_nxt;
	logic [cs_pro_pkg::CS_BITS-1:0]    shift_r, shift_nxt;
	logic [cs_pro_pkg::CS_BITS-1:0]    held_r, held_nxt;
	logic [cs_pro_pkg::CNT_W-1:0]      cnt_r, cnt_nxt;
	logic                              ready_r, ready_nxt;
	logic                              commit;
	logic [7:0]                        rd_data_r, rd_data_nxt;
	cs_pro_pkg::cs_decoded_t           dec_r, dec_nxt;
	cs_pro_pkg::byte0_t                b0;
	cs_pro_pkg::byte1_t                b1;
	cs_pro_pkg::byte2_t                b2;
	cs_pro_pkg::byte3_t                b3;
	cs_pro_pkg::byte4_t                b4;

	// Reverses the bit order of a 7-bit field
	function automatic logic [6:0] rev7(input logic [6:0] v);
		logic [6:0] r;
		r = '0;
		for (int i = 0; i < 7; i++) begin
			r[i] = v[6-i];
		end
		return r;
	endfunction

	// Framing: bits arrive bit 0 first, so they shift in from the top
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		shift_nxt = shift_r;
		held_nxt  = held_r;
		ready_nxt = ready_r;
		commit    = 1'b0;
		if (frame_valid) begin
			shift_nxt = {cs_bit, shift_r[cs_pro_pkg::CS_BITS-1:1]};
		end
		case (state_r)
			SYNC_WAIT: begin
				if (frame_valid && block_start) begin
					cnt_nxt   = cs_pro_pkg::CNT_FIRST;
					state_nxt = CAPTURE;
				end
			end
			CAPTURE: begin
				if (frame_valid && block_start) begin
					cnt_nxt = cs_pro_pkg::CNT_FIRST; // Early start: partial block dropped
				end else if (frame_valid && cnt_r == cs_pro_pkg::LAST_BIT) begin
					commit    = 1'b1;
					held_nxt  = shift_nxt;
					ready_nxt = 1'b1;
					state_nxt = SYNC_WAIT;
				end else if (frame_valid) begin
					cnt_nxt = cnt_r + cs_pro_pkg::CNT_FIRST;
				end
			end
			default: state_nxt = SYNC_WAIT;
		endcase
	end

	// Framing registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_r <= SYNC_WAIT;
			cnt_r   <= '0;
			shift_r <= '0;
			held_r  <= '0;
			ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			shift_r <= shift_nxt;
			held_r  <= held_nxt;
			ready_r <= ready_nxt;
		end
	end

	// Read window; addresses past the last byte answer zero
	always_comb begin
		rd_data_nxt = rd_data_r;
		if (rd_en) begin
			if (rd_addr <= cs_pro_pkg::OFS_LAST) begin
				rd_data_nxt = held_r[{rd_addr, 3'h0} +: 8];
			end else begin
				rd_data_nxt = cs_pro_pkg::BYTE_ZERO;
			end
		end
	end

	// Field decode from the held block, registered so outputs never glitch
	always_comb begin
		b0 = cs_pro_pkg::byte0_t'(held_r[{cs_pro_pkg::OFS_RATE_EMPHASIS, 3'h0} +: 8]);
		b1 = cs_pro_pkg::byte1_t'(held_r[{cs_pro_pkg::OFS_USER_CHMODE, 3'h0} +: 8]);
		b2 = cs_pro_pkg::byte2_t'(held_r[{cs_pro_pkg::OFS_LEVEL_WORDLEN, 3'h0} +: 8]);
		b3 = cs_pro_pkg::byte3_t'(held_r[{cs_pro_pkg::OFS_CHANNEL_ID, 3'h0} +: 8]);
		b4 = cs_pro_pkg::byte4_t'(held_r[{cs_pro_pkg::OFS_EXT_RATE, 3'h0} +: 8]);
		dec_nxt = '0;
		case (b0.rate)
			cs_pro_pkg::FS_C48: dec_nxt.base_rate = cs_pro_pkg::FS_48K;
			cs_pro_pkg::FS_C44: dec_nxt.base_rate = cs_pro_pkg::FS_44K1;
			cs_pro_pkg::FS_C32: dec_nxt.base_rate = cs_pro_pkg::FS_32K;
			default:            dec_nxt.base_rate = cs_pro_pkg::FS_NONE; // Byte 4 decides
		endcase
		dec_nxt.locked       = !b0.unlocked;
		dec_nxt.non_audio    = b0.non_audio;
		dec_nxt.professional = b0.professional;
		case (b0.emph)
			cs_pro_pkg::EM_C_NI:   dec_nxt.emph = cs_pro_pkg::EMPH_NOT_IND;
			cs_pro_pkg::EM_C_NONE: dec_nxt.emph = cs_pro_pkg::EMPH_NONE;
			cs_pro_pkg::EM_C_CD:   dec_nxt.emph = cs_pro_pkg::EMPH_CD;
			cs_pro_pkg::EM_C_J17:  dec_nxt.emph = cs_pro_pkg::EMPH_J17;
			default:               dec_nxt.emph = cs_pro_pkg::EMPH_OTHER;
		endcase
		case (b1.user_mgmt)
			cs_pro_pkg::UB_C_NONE: dec_nxt.user_mgmt = cs_pro_pkg::UB_NONE;
			cs_pro_pkg::UB_C_CS:   dec_nxt.user_mgmt = cs_pro_pkg::UB_CHSTAT;
			cs_pro_pkg::UB_C_AES:  dec_nxt.user_mgmt = cs_pro_pkg::UB_AES18;
			cs_pro_pkg::UB_C_USR:  dec_nxt.user_mgmt = cs_pro_pkg::UB_USER;
			cs_pro_pkg::UB_C_CON:  dec_nxt.user_mgmt = cs_pro_pkg::UB_CONSUMER;
			default:               dec_nxt.user_mgmt = cs_pro_pkg::UB_OTHER;
		endcase
		case (b1.chan_mode)
			cs_pro_pkg::CM_C_NI:   dec_nxt.chan_mode = cs_pro_pkg::CM_NOT_IND; // Kept as not indicated, separate from two channel
			cs_pro_pkg::CM_C_TWO:  dec_nxt.chan_mode = cs_pro_pkg::CM_TWO;
			cs_pro_pkg::CM_C_MONO: dec_nxt.chan_mode = cs_pro_pkg::CM_MONO;
			cs_pro_pkg::CM_C_PS:   dec_nxt.chan_mode = cs_pro_pkg::CM_PRI_SEC;
			cs_pro_pkg::CM_C_ST:   dec_nxt.chan_mode = cs_pro_pkg::CM_STEREO;
			cs_pro_pkg::CM_C_U1,
			cs_pro_pkg::CM_C_U2:   dec_nxt.chan_mode = cs_pro_pkg::CM_USER;
			cs_pro_pkg::CM_C_SD:   dec_nxt.chan_mode = cs_pro_pkg::CM_SCDR;
			cs_pro_pkg::CM_C_SDL:  dec_nxt.chan_mode = cs_pro_pkg::CM_SCDR_LEFT;
			cs_pro_pkg::CM_C_SDR:  dec_nxt.chan_mode = cs_pro_pkg::CM_SCDR_RIGHT;
			cs_pro_pkg::CM_C_MC:   dec_nxt.chan_mode = cs_pro_pkg::CM_MULTI;
			default:               dec_nxt.chan_mode = cs_pro_pkg::CM_OTHER;
		endcase
		case (b2.align)
			cs_pro_pkg::AL_C_NONE: dec_nxt.align = cs_pro_pkg::AL_NONE;
			cs_pro_pkg::AL_C_20:   dec_nxt.align = cs_pro_pkg::AL_M20;
			cs_pro_pkg::AL_C_18:   dec_nxt.align = cs_pro_pkg::AL_M18;
			default:               dec_nxt.align = cs_pro_pkg::AL_OTHER;
		endcase
		case (b2.aux)
			cs_pro_pkg::AX_C_UNDEF: dec_nxt.aux = cs_pro_pkg::AUX_UNDEF;
			cs_pro_pkg::AX_C_MAIN:  dec_nxt.aux = cs_pro_pkg::AUX_MAIN;
			cs_pro_pkg::AX_C_COORD: dec_nxt.aux = cs_pro_pkg::AUX_COORD;
			default:                dec_nxt.aux = cs_pro_pkg::AUX_RSVD;
		endcase
		// The word length table is decoded for every aux code except AX_C_MAIN, which reads as not indicated
		dec_nxt.word_len = cs_pro_pkg::WL_NI;
		if (b2.aux != cs_pro_pkg::AX_C_MAIN) begin
			case (b2.word_len)
				cs_pro_pkg::WL_C_23: dec_nxt.word_len = cs_pro_pkg::WL_23;
				cs_pro_pkg::WL_C_22: dec_nxt.word_len = cs_pro_pkg::WL_22;
				cs_pro_pkg::WL_C_21: dec_nxt.word_len = cs_pro_pkg::WL_21;
				cs_pro_pkg::WL_C_20: dec_nxt.word_len = cs_pro_pkg::WL_20;
				cs_pro_pkg::WL_C_24: dec_nxt.word_len = cs_pro_pkg::WL_24;
				default:             dec_nxt.word_len = cs_pro_pkg::WL_NI;
			endcase
		end
		dec_nxt.multi = b3.multi;
		if (!b3.multi) begin
			dec_nxt.chan_num = {1'b0, rev7(b3.chan)} + cs_pro_pkg::CHAN_ONE;
		end else begin
			dec_nxt.multi_mode = b3.chan[6:4];
			dec_nxt.chan_num   = {4'h0, b3.chan[0], b3.chan[1], b3.chan[2], b3.chan[3]};
		end
		dec_nxt.fs_scaled = b4.fs_scale;
		case (b4.ext_rate)
			cs_pro_pkg::XR_C_24:   dec_nxt.ext_rate = cs_pro_pkg::XR_24K;
			cs_pro_pkg::XR_C_22:   dec_nxt.ext_rate = cs_pro_pkg::XR_22K05;
			cs_pro_pkg::XR_C_88:   dec_nxt.ext_rate = cs_pro_pkg::XR_88K2;
			cs_pro_pkg::XR_C_176:  dec_nxt.ext_rate = cs_pro_pkg::XR_176K4;
			cs_pro_pkg::XR_C_192:  dec_nxt.ext_rate = cs_pro_pkg::XR_192K;
			cs_pro_pkg::XR_C_USER: dec_nxt.ext_rate = cs_pro_pkg::XR_USER;
			default:               dec_nxt.ext_rate = cs_pro_pkg::XR_NONE;
		endcase
	end

	// Read data and decoded view registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rd_data_r <= '0;
			dec_r     <= '0;
		end else begin
			rd_data_r <= rd_data_nxt;
			dec_r     <= dec_nxt;
		end
	end

	assign rd_data     = rd_data_r;
	assign block_ready = ready_r;
	assign decoded     = dec_r;

	a_held_only_commit: assert property (@(posedge mclk) disable iff (!resetn)
		!commit |=> $stable(held_r)) else $error("held block changed outside a boundary");
	a_commit_at_last: assert property (@(posedge mclk) disable iff (!resetn)
		commit |-> (state_r == CAPTURE && cnt_r == cs_pro_pkg::LAST_BIT && frame_valid && !block_start))
		else $error("commit not at bit 191");
	a_read_window: assert property (@(posedge mclk) disable iff (!resetn)
		rd_en && rd_addr <= cs_pro_pkg::OFS_LAST |=> rd_data == $past(held_r[{rd_addr, 3'h0} +: 8]))
		else $error("read byte mismatch");
	a_read_unmapped: assert property (@(posedge mclk) disable iff (!resetn)
		rd_en && rd_addr > cs_pro_pkg::OFS_LAST |=> rd_data == cs_pro_pkg::BYTE_ZERO)
		else $error("unmapped read not zero");
	// Skips the edge right after reset, where decoded still shows its reset zeros
	a_lock_flag: assert property (@(posedge mclk) disable iff (!resetn)
		$past(resetn) |-> decoded.locked == !$past(held_r[5])) else $error("lock flag wrong");
	a_rate_48k: assert property (@(posedge mclk) disable iff (!resetn)
		held_r[7:6] == cs_pro_pkg::FS_C48 |=> decoded.base_rate == cs_pro_pkg::FS_48K)
		else $error("48 kHz not decoded");
	a_chan_plain: assert property (@(posedge mclk) disable iff (!resetn)
		!held_r[31] && held_r[30:24] == 7'h12 |=> decoded.chan_num == 8'h25)
		else $error("channel number wrong");
	a_ext_192k: assert property (@(posedge mclk) disable iff (!resetn)
		held_r[38:35] == cs_pro_pkg::XR_C_192 |=> decoded.ext_rate == cs_pro_pkg::XR_192K)
		else $error("192 kHz not decoded");
	a_ready_after: assert property (@(posedge mclk) disable iff (!resetn)
		commit |=> block_ready && held_r[cs_pro_pkg::CS_BITS-1] == $past(cs_bit))
		else $error("commit did not land");
endmodule

/* File: sim/cs_source_model.sv */
// Serial source model that sends channel status blocks frame by frame
`timescale 1ns/1ns
module cs_source_model (
	input  wire logic mclk,
	output logic      frame_valid,
	output logic      block_start,
	output logic      cs_bit
);
	// Quiet until the first block is sent
	initial begin
		frame_valid = 1'b0;
		block_start = 1'b0;
		cs_bit      = 1'b0;
	end

	// Sends n frames with gap idle cycles after each, then ex stray frames.
	// The status line toggles while idle, so a stale level is never mistaken for data.
	task automatic send(input logic [191:0] blk, input int n, input int gap, input int ex);
		for (int j = 0; j < n + ex; j++) begin
			@(posedge mclk);
			frame_valid <= 1'b1;
			block_start <= (j == 0);
			cs_bit      <= (j < 192) ? blk[j] : ~blk[j - 192];
			repeat (gap) begin
				@(posedge mclk);
				frame_valid <= 1'b0;
				block_start <= 1'b0;
				cs_bit      <= ~cs_bit;
			end
		end
		@(posedge mclk);
		frame_valid <= 1'b0;
		block_start <= 1'b0;
		cs_bit      <= ~cs_bit;
	endtask
endmodule

/* File: sim/pro_channel_status_decoder_tb.sv */
// Self-checking testbench for the professional channel status decoder
`timescale 1ns/1ns
module pro_channel_status_decoder_tb;
	logic                    mclk;
	logic                    resetn;
	logic                    frame_valid;
	logic                    block_start;
	logic                    cs_bit;
	logic                    rd_en;
	logic [4:0]              rd_addr;
	logic [7:0]              rd_data;
	logic                    block_ready;
	cs_pro_pkg::cs_decoded_t dec;
	int                      mismatches;
	int                      cmp_count;
	logic [191:0]            blk;
	logic [191:0]            prev;
	logic [7:0]              g;
	logic [7:0]              g2;
	logic [7:0]              b3;
	logic [7:0]              ch;
	// Expected enum positions indexed by raw code; word lengths in bits
	int rt_x [4]  = '{0, 2, 1, 3};
	int em_x [8]  = '{0, 1, 4, 2, 4, 4, 4, 3};
	int ub_x [16] = '{0, 5, 4, 5, 2, 5, 5, 5, 1, 5, 5, 5, 3, 5, 5, 5};
	int cm_x [16] = '{0, 7, 4, 10, 2, 10, 5, 10, 1, 8, 5, 10, 3, 10, 6, 9};
	int ax_x [8]  = '{0, 3, 2, 3, 1, 3, 3, 3};
	int wl_x [8]  = '{0, 20, 22, 0, 23, 24, 21, 0};
	int xr_x [16] = '{0, 1, 0, 5, 0, 3, 0, 0, 0, 2, 0, 4, 0, 0, 0, 6};

	cs_source_model i_src (
		.mclk        (mclk),
		.frame_valid (frame_valid),
		.block_start (block_start),
		.cs_bit      (cs_bit)
	);

	pro_channel_status_decoder i_dut (
		.mclk        (mclk),
		.resetn      (resetn),
		.frame_valid (frame_valid),
		.block_start (block_start),
		.cs_bit      (cs_bit),
		.rd_en       (rd_en),
		.rd_addr     (rd_addr),
		.rd_data     (rd_data),
		.block_ready (block_ready),
		.decoded     (dec)
	);

	// 25 MHz master clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// One read; data is taken one edge after the request
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge mclk);
		rd_en   <= 1'b1;
		rd_addr <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask

	task automatic finish_test;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Watchdog: the tests need about 7700 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		mismatches++;
		finish_test();
	end

	// Sixteen blocks sweep every code of bytes 0, 1, 2 and 4 and the multichannel mode; odd ones follow an aborted block
	initial begin
		resetn     = 1'b0;
		rd_en      = 1'b0;
		rd_addr    = 5'h00;
		mismatches = 0;
		cmp_count  = 0;
		prev       = '0;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		rd(5'h00, g);
		chk(g, 8'h00);
		chk(8'(block_ready), 8'h00);
		chk(dec.chan_num, 8'h01);
		chk(8'(dec.locked), 8'h01);
		for (int i = 0; i < 16; i++) begin
			blk[7:0]   = {i[1:0], i[2], i[2:0], i[3], 1'b1};
			blk[15:8]  = {i[3:0], ~i[3:0]};
			blk[23:16] = {i[3:2], i[2:0], i[3:1]};
			blk[31:24] = {i[0], i[3:0], i[2:0]};
			blk[39:32] = {i[0], i[3:0], 3'h5};
			for (int k = 5; k < 24; k++) blk[8*k+:8] = 8'(k * 29 + i);
			if (i[0]) i_src.send(~blk, 100, 0, 0);
			fork
				i_src.send(blk, 192, i % 3, i[0] ? 0 : 5);
				begin
					repeat (150) @(posedge mclk);
					rd(5'h00, g2);
				end
			join
			// The last frame may commit on the edge that ended the send
			@(negedge mclk);
			chk(g2, prev[7:0]);
			chk(8'(block_ready), 8'h01);
			for (int k = 0; k < 24; k++) begin
				rd(5'(k), g);
				chk(g, blk[8*k+:8]);
			end
			rd(5'(24 + i % 8), g);
			chk(g, 8'h00);
			chk(8'(dec.base_rate), 8'(rt_x[i % 4]));
			chk(8'(dec.emph), 8'(em_x[i % 8]));
			chk(8'(dec.user_mgmt), 8'(ub_x[i]));
			chk(8'(dec.chan_mode), 8'(cm_x[15 - i]));
			chk(8'(dec.align), 8'(rt_x[i / 4]));
			chk(8'(dec.word_len), (i / 2 == 4) ? 8'h00 : 8'(wl_x[i % 8]));
			chk(8'(dec.aux), 8'(ax_x[i / 2]));
			// Channel number worked out by reversing the identity bits
			b3 = blk[31:24];
			for (int k = 0; k < 7; k++) ch[k] = b3[6 - k];
			ch[7] = 1'b0;
			if (b3[7]) ch = {4'h0, b3[0], b3[1], b3[2], b3[3]};
			else ch = ch + 8'h01;
			chk(dec.chan_num, ch);
			chk(8'(dec.multi_mode), b3[7] ? 8'(b3[6:4]) : 8'h00);
			chk(8'(dec.multi), 8'(b3[7]));
			chk(8'(dec.fs_scaled), 8'(i % 2));
			chk(8'(dec.ext_rate), 8'(xr_x[i]));
			chk(8'({dec.locked, dec.non_audio, dec.professional}), 8'({~i[2], i[3], 1'b1}));
			prev = blk;
		end
		// Mid-run reset must empty the window and drop the ready flag
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		rd(5'h00, g);
		chk(g, 8'h00);
		chk(8'(block_ready), 8'h00);
		chk(dec.chan_num, 8'h01);
		finish_test();
	end
endmodule
